// [hdl/phw_consts.vh]
// constants for the program health watchdog
`ifndef PHW_CONSTS_VH
`define PHW_CONSTS_VH

// register offsets (byte addresses on the plain register port)
`define PHW_ADDR_W          4
`define PHW_OFF_OPTIONS     4'h0
`define PHW_OFF_OPTIONS2    4'h4
`define PHW_OFF_RSTSTAT     4'h8
`define PHW_OFF_IRQSTAT     4'hc

// field positions
`define PHW_BIT_ENABLE      0
`define PHW_BIT_TIMEOUT     1
`define PHW_BIT_CLKSEL      0
`define PHW_BIT_SRC_WDOG    0
`define PHW_BIT_SRC_EXT     1

// reset values
`define PHW_RST_ENABLE      1'b1
`define PHW_RST_TIMEOUT     1'b1
`define PHW_RST_CLKSEL      1'b1

// overflow bit positions of the 19-bit counter
`define PHW_CNT_W           18
`define PHW_POS_SLOW_SHORT  5
`define PHW_POS_SLOW_LONG   8
`define PHW_POS_BUS_SHORT   13
`define PHW_POS_BUS_LONG    18

// slow tick period in ns, nominal 1 ms
`define PHW_SLOW_PERIOD_NS  1000000
`define PHW_MCLK_PERIOD_NS  10

`endif

// [hdl/phw_watchdog.v]
// program health watchdog: overflow counter, option registers, reset request
`timescale 1ns/1ps
`include "phw_consts.vh"
// What this block does
// - every reset sets the watchdog enable bit
// - enable cleared means no watchdog reset ever
// - any write to status address clears counter
// - that write leaves status contents unchanged
// - clock select: bus clock or slow tick
// - timeout select picks short or long overflow
// - default is bus clock, long timeout
// - overflow while enabled requests system reset
// - option registers accept only first write
// - first option write also clears counter
// - counter holds in background debug mode
// - bus clock: counter freezes during stop
// - slow clock: counter zeroed on stop entry
// - watchdog reset recorded in status source bit
module phw_watchdog #(
  parameter integer SLOW_PERIOD_NS = `PHW_SLOW_PERIOD_NS
) (
  input  wire                   mclk,
  input  wire                   rst_b,
  input  wire [`PHW_ADDR_W-1:0] regAddr,
  input  wire [7:0]             regWdata,
  input  wire                   regWr,
  input  wire                   regRd,
  output reg  [7:0]             regRdata,
  input  wire                   debugMode,
  input  wire                   stopMode,
  input  wire                   extResetSeen,
  output wire                   sysResetReq,
  output wire                   irq
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  localparam integer SLOW_CYC_RAW = SLOW_PERIOD_NS / `PHW_MCLK_PERIOD_NS;
  localparam integer SLOW_CYC     = (SLOW_CYC_RAW < 1) ? 1 : SLOW_CYC_RAW;

  reg  [1:0] rstSync_q;
  wire       rstSync_b = rstSync_q[1];

  // async assert, sync release through two flops; every other flop in
  // the block resets from this copy, so release never lands mid-cycle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  // debug, stop and external reset come from other logic domains;
  // each pin gets its own two-flop chain and only the second flop is read
  localparam integer PIN_N = 3;

  wire [PIN_N-1:0] pinRaw = {extResetSeen, stopMode, debugMode};
  wire [PIN_N-1:0] pinSync;

  genvar p;
  generate
    for (p = 0; p < PIN_N; p = p + 1) begin : g_pinSync
      reg meta_q;
      reg sync_q;
      always @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= pinRaw[p];
          sync_q <= meta_q;
        end
      end
      assign pinSync[p] = sync_q;
    end
  endgenerate

  wire dbgS  = pinSync[0];
  wire stopS = pinSync[1];
  wire extS  = pinSync[2];

  // ----------------------------------------------------------------
  // write-once option registers
  // ----------------------------------------------------------------
  reg enable_q;
  reg timeoutSel_q;
  reg clkSel_q;
  reg opt1Locked_q;
  reg opt2Locked_q;

  // decoded strobes, each one cycle long like the bus strobes
  wire wrOpt1    = regWr && (regAddr == `PHW_OFF_OPTIONS);
  wire wrOpt2    = regWr && (regAddr == `PHW_OFF_OPTIONS2);
  wire wrStat    = regWr && (regAddr == `PHW_OFF_RSTSTAT);
  wire wrIrqClr  = regWr && (regAddr == `PHW_OFF_IRQSTAT);
  wire opt1Take  = wrOpt1 && !opt1Locked_q;
  wire opt2Take  = wrOpt2 && !opt2Locked_q;
  wire serviceEv = wrStat || opt1Take || opt2Take;

  // later writes are dropped silently so a runaway program cannot undo setup
  // the two registers lock independently of each other
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      enable_q     <= `PHW_RST_ENABLE;
      timeoutSel_q <= `PHW_RST_TIMEOUT;
      clkSel_q     <= `PHW_RST_CLKSEL;
      opt1Locked_q <= 1'b0;
      opt2Locked_q <= 1'b0;
    end else begin
      if (opt1Take) begin
        enable_q     <= regWdata[`PHW_BIT_ENABLE];
        timeoutSel_q <= regWdata[`PHW_BIT_TIMEOUT];
        opt1Locked_q <= 1'b1;
      end
      if (opt2Take) begin
        clkSel_q     <= regWdata[`PHW_BIT_CLKSEL];
        opt2Locked_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // slow tick: stands in for the ~1 kHz internal oscillator
  // ----------------------------------------------------------------
  // the slow source is derived from mclk here, so the service pulse
  // is held pending until the next slow tick instead of crossing clocks
  // the divider runs on through debug and stop; only the counter holds
  reg [31:0] slowDiv_q;
  reg        slowTick_q;
  reg        svcPend_q;

  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      slowDiv_q  <= 32'h0;
      slowTick_q <= 1'b0;
    end else if (slowDiv_q == SLOW_CYC - 1) begin
      slowDiv_q  <= 32'h0;
      slowTick_q <= 1'b1;
    end else begin
      slowDiv_q  <= slowDiv_q + 32'h1;
      slowTick_q <= 1'b0;
    end
  end

  // pending service held until the slow domain consumes it; set wins
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      svcPend_q <= 1'b0;
    end else if (serviceEv) begin
      svcPend_q <= 1'b1;
    end else if (slowTick_q || clkSel_q) begin
      svcPend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  // the counter carries one bit above the widest span, so the longest
  // timeout shows up as its top bit rather than as a silent wrap
  reg  [`PHW_CNT_W:0] count_q;
  reg  [`PHW_CNT_W:0] count_d;
  reg                 stopPrev_q;
  reg  [4:0]          ovfPos;

  // overflow bit positions sized to the select, one per clock/timeout pair
  localparam [4:0] POS_SLOW_SHORT = `PHW_POS_SLOW_SHORT;
  localparam [4:0] POS_SLOW_LONG  = `PHW_POS_SLOW_LONG;
  localparam [4:0] POS_BUS_SHORT  = `PHW_POS_BUS_SHORT;
  localparam [4:0] POS_BUS_LONG   = `PHW_POS_BUS_LONG;

  // overflow bit chosen from clock and timeout selects; the counter is
  // zeroed whenever either select changes, so no stale higher bit is
  // ever left set to trip a shorter timeout early
  always @* begin
    case ({clkSel_q, timeoutSel_q})
      2'b00:   ovfPos = POS_SLOW_SHORT;
      2'b01:   ovfPos = POS_SLOW_LONG;
      2'b10:   ovfPos = POS_BUS_SHORT;
      default: ovfPos = POS_BUS_LONG;
    endcase
  end

  wire overflow = enable_q && count_q[ovfPos];
  wire advance  = clkSel_q ? 1'b1 : slowTick_q;
  wire stopEnter = stopS && !stopPrev_q;

  // next counter value; debug and stop hold it
  // a service beats the debug and stop holds, so software can still
  // clear the count while the core is halted
  always @* begin
    count_d = count_q;
    if (!enable_q || overflow) begin
      count_d = {(`PHW_CNT_W+1){1'b0}};
    end else if (serviceEv || (svcPend_q && !clkSel_q && slowTick_q)) begin
      count_d = {(`PHW_CNT_W+1){1'b0}};
    end else if (!clkSel_q && stopEnter) begin
      count_d = {(`PHW_CNT_W+1){1'b0}};
    end else if (dbgS || stopS) begin
      count_d = count_q;
    end else if (advance) begin
      count_d = count_q + {{`PHW_CNT_W{1'b0}}, 1'b1};
    end
  end

  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      count_q    <= {(`PHW_CNT_W+1){1'b0}};
      stopPrev_q <= 1'b0;
    end else begin
      count_q    <= count_d;
      stopPrev_q <= stopS;
    end
  end

  // reset request is a one-cycle pulse the system reset controller acts on
  // registered so decode glitches on the overflow bit never reach it
  reg resetReq_q;
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      resetReq_q <= 1'b0;
    end else begin
      resetReq_q <= overflow;
    end
  end
  assign sysResetReq = resetReq_q;

  // ----------------------------------------------------------------
  // reset source status and interrupt flags
  // ----------------------------------------------------------------
  // the source record is cleared by this block's own reset; the system
  // reset that an overflow requests is expected not to reach this block,
  // so software can still read why the part restarted
  localparam integer IRQ_N = 2;

  reg  [1:0]       rstSrc_q;
  reg  [IRQ_N-1:0] irqEn_q;
  wire [IRQ_N-1:0] irqStat;
  wire [IRQ_N-1:0] events = {extS, overflow};   // bit0 overflow, bit1 external

  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rstSrc_q <= 2'h0;
    end else if (overflow) begin
      rstSrc_q <= 2'h1 << `PHW_BIT_SRC_WDOG;
    end else if (extS) begin
      rstSrc_q <= 2'h1 << `PHW_BIT_SRC_EXT;
    end
  end

  // interrupt enables are loaded by the service write
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      irqEn_q <= 2'h0;
    end else if (wrStat) begin
      irqEn_q <= regWdata[1:0];
    end
  end

  // one sticky flag per event; an event in the clear cycle wins, so an
  // overflow that lands on the clear write is never lost
  genvar f;
  generate
    for (f = 0; f < IRQ_N; f = f + 1) begin : g_irqFlag
      reg stat_q;
      always @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
          stat_q <= 1'b0;
        end else if (events[f]) begin
          stat_q <= 1'b1;
        end else if (wrIrqClr && regWdata[f]) begin
          stat_q <= 1'b0;
        end
      end
      assign irqStat[f] = stat_q;
    end
  endgenerate
  assign irq = |(irqStat & irqEn_q);

  // ----------------------------------------------------------------
  // read port: data one cycle after the strobe
  // ----------------------------------------------------------------
  // data is zero outside the answer cycle, so a stale value is never seen
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      regRdata <= 8'h0;
    end else if (regRd) begin
      case (regAddr)
        `PHW_OFF_OPTIONS:  regRdata <= {6'h0, timeoutSel_q, enable_q};
        `PHW_OFF_OPTIONS2: regRdata <= {7'h0, clkSel_q};
        `PHW_OFF_RSTSTAT:  regRdata <= {6'h0, rstSrc_q};
        `PHW_OFF_IRQSTAT:  regRdata <= {2'h0, irqEn_q, 2'h0, irqStat};
        default:           regRdata <= 8'h0;
      endcase
    end else begin
      regRdata <= 8'h0;
    end
  end

endmodule // phw_watchdog

// [tb/phw_watchdog_checker.sv]
// assertion checker for the program health watchdog
`timescale 1ns/1ps
`include "phw_consts.vh"
module phw_watchdog_checker #(
  parameter integer SLOW_PERIOD_NS = `PHW_SLOW_PERIOD_NS
) (
  input wire       mclk,
  input wire       rst_b,
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire       regWr,
  input wire       regRd,
  input wire [7:0] regRdata,
  input wire       debugMode,
  input wire       stopMode,
  input wire       sysResetReq,
  input wire       irq
);
  localparam int SlowGap = 31 * (SLOW_PERIOD_NS / `PHW_MCLK_PERIOD_NS);
  localparam int MinGap  = (SlowGap < 8191) ? SlowGap : 8191;
  logic [19:0] gap_q;
  logic        opt0_q;
  logic        off_q;
  wire         svc = regWr && regAddr == `PHW_OFF_RSTSTAT;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // cycles since the last clear: never more than one cycle shorter than the real count, so never too strict
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q  <= 20'h0;
      opt0_q <= 1'b0;
      off_q  <= 1'b0;
    end else begin
      gap_q  <= (svc || sysResetReq) ? 20'h0 : gap_q + {19'h0, ~&gap_q};
      opt0_q <= opt0_q || (regWr && regAddr == `PHW_OFF_OPTIONS);
      off_q  <= off_q || (regWr && regAddr == `PHW_OFF_OPTIONS && !opt0_q && !regWdata[0]);
    end
  end
  read_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not zero outside a read");
  reset_pulse_a: assert property (sysResetReq |=> !sysResetReq)
    else $error("reset request longer than one cycle");
  service_clear_a: assert property (svc |=> ##1 !sysResetReq [*7])
    else $error("reset request right after service");
  debug_hold_a: assert property (debugMode [*5] |-> !sysResetReq)
    else $error("reset request in debug");
  stop_hold_a: assert property (stopMode [*5] |-> !sysResetReq)
    else $error("reset request in stop");
  disabled_quiet_a: assert property (off_q |-> !sysResetReq)
    else $error("reset request while disabled");
  overflow_gap_a: assert property (sysResetReq |-> gap_q >= MinGap)
    else $error("overflow too early");
  irq_mask_a: assert property (svc && regWdata[1:0] == 2'h0 |=> !irq)
    else $error("interrupt not masked");
endmodule // phw_watchdog_checker
bind phw_watchdog phw_watchdog_checker #(.SLOW_PERIOD_NS(SLOW_PERIOD_NS)) chk (
  .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .debugMode(debugMode), .stopMode(stopMode),
  .sysResetReq(sysResetReq), .irq(irq));

// [tb/phw_watchdog_bench.sv]
// self-checking bench for the program health watchdog
`timescale 1ns/1ps
module phw_watchdog_bench;
  logic       mclk = 0, rst_b = 0, regWr = 0, regRd = 0;
  logic       debugMode = 0, stopMode = 0, extResetSeen = 0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  wire  [7:0] regRdata;
  wire        sysResetReq, irq;
  int         failures, cmp_count, n;
  // slow tick shortened to ten clocks so slow overflows fit the run
  phw_watchdog #(.SLOW_PERIOD_NS(100)) dut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .debugMode(debugMode), .stopMode(stopMode), .extResetSeen(extResetSeen),
    .sysResetReq(sysResetReq), .irq(irq));
  initial forever #5 mclk = ~mclk;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  // reset held eight cycles, then the internal copy is given time to release
  task automatic rst();
    @(posedge mclk) rst_b <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  // bounded wait for the reset request, counting clocks
  task automatic ovf(output int c, input int lim);
    c = 0;
    while (sysResetReq !== 1'b1 && c < lim) begin
      @(posedge mclk);
      #1 c++;
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst();
    rd(4'h0, 8'h03);
    rd(4'h4, 8'h01);
    rd(4'h2, 8'h00);
    wr(4'h8, 8'h01);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h03);
    wr(4'h4, 8'h01);
    wr(4'h4, 8'h00);
    rd(4'h0, 8'h01);
    rd(4'h4, 8'h01);
    @(posedge mclk) debugMode <= 1'b1;
    repeat (9000) @(posedge mclk);
    debugMode <= 1'b0;
    ovf(n, 20000);
    chk({7'h0, n > 8184 && n < 8200}, 8'h01);
    @(posedge mclk);
    stopMode <= 1'b1;
    repeat (9000) @(posedge mclk);
    stopMode <= 1'b0;
    ovf(n, 20000);
    chk({7'h0, n > 8184 && n < 8200}, 8'h01);
    rd(4'h8, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rd(4'hc, 8'h11);
    wr(4'h8, 8'hfc);
    rd(4'h8, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(4'hc, 8'h01);
    rd(4'hc, 8'h00);
    @(posedge mclk) extResetSeen <= 1'b1;
    repeat (4) @(posedge mclk);
    extResetSeen <= 1'b0;
    wr(4'h8, 8'h02);
    chk({7'h0, irq}, 8'h01);
    wr(4'hc, 8'h02);
    chk({7'h0, irq}, 8'h00);
    rd(4'h8, 8'h02);
    rst();
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h01);
    repeat (200) @(posedge mclk);
    stopMode <= 1'b1;
    repeat (50) @(posedge mclk);
    stopMode <= 1'b0;
    ovf(n, 2000);
    chk({7'h0, n > 280 && n < 345}, 8'h01);
    rst();
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h00);
    ovf(n, 1000);
    chk({7'h0, n == 1000}, 8'h01);
    final_report();
  end
  // hang guard, well beyond the roughly 36k clocks the tests take
  initial begin
    #600000;
    failures++;
    final_report();
  end
endmodule // phw_watchdog_bench
